// ---- bist_pkg.sv ----
// Summary of operation
// - Self-test logic stays idle and harmless unless a run bit is set.
// - Link run bit enables the pattern generator and signature compressor for that core.
// - Fault-free link core leaves 5B6B in its signature register.
// - Link test runs 62820 patterns from a 16-bit generator, one per byte clock.
// - Signature freezes at completion so the host can read it.
// - Completion raises the interrupt; only clearing the run bit or a reset clears it.
// - Clearing the run bit before completion aborts the test.
// - Writing media-access control A with run bit set starts that test.
// - Media-access test runs 65535 patterns from a 16-bit generator.
// - Media-access signature depends on every setup register value at test start.
// - Symbol clock, receive data and transmit control pins never affect the result.
// - Documented setup vectors give 9FA2, 9324, 8445 at signature address 6A.
package bist_pkg;

    // Data path widths and setup register count
    localparam int unsigned SIG_WIDTH  = 16;
    localparam int unsigned ADDR_WIDTH = 8;
    localparam int unsigned SETUP_REGS = 8;

    // Register offsets on the register access port
    localparam logic [7:0] LINK_CTRL_A_OFFSET   = 8'h00;
    localparam logic [7:0] LINK_STATUS_OFFSET   = 8'h01;
    localparam logic [7:0] LINK_SIG_OFFSET      = 8'h0f;
    localparam logic [7:0] MAC_CTRL_A_OFFSET    = 8'h40;
    localparam logic [7:0] MAC_CTRL_B_OFFSET    = 8'h41;
    localparam logic [7:0] SHORT_ADDR_OFFSET    = 8'h50;
    localparam logic [7:0] LONG_ADDR_A_OFFSET   = 8'h51;
    localparam logic [7:0] LONG_ADDR_B_OFFSET   = 8'h52;
    localparam logic [7:0] LONG_ADDR_C_OFFSET   = 8'h53;
    localparam logic [7:0] ROTATION_OFFSET      = 8'h54;
    localparam logic [7:0] TIMERS_OFFSET        = 8'h55;
    localparam logic [7:0] MAC_SIG_OFFSET       = 8'h6a;

    // Field positions
    localparam int unsigned RUN_BIT      = 2;
    localparam int unsigned LOOPBACK_BIT = 3;
    localparam int unsigned STAT_LINK_DONE = 0;
    localparam int unsigned STAT_MAC_DONE  = 1;
    localparam int unsigned STAT_INT_PIN   = 2;

    // Values after reset
    localparam logic [15:0] CTRL_RESET  = 16'h0000;
    localparam logic [15:0] SETUP_RESET = 16'h0000;

    // Generator seed and feedback (x^16 + x^5 + x^3 + x^2 + 1)
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_POLY = 16'h002d;

    // Test lengths and timing
    localparam int unsigned BYTE_CLOCK_NS = 80;
    localparam int unsigned LINK_PATTERNS = 62820;
    localparam int unsigned MAC_PATTERNS  = 65535;

    // Expected fault-free signatures
    localparam logic [15:0] LINK_SIG_GOOD = 16'h5b6b;
    localparam logic [15:0] MAC_SIG_TEST1 = 16'h9fa2;
    localparam logic [15:0] MAC_SIG_TEST2 = 16'h9324;
    localparam logic [15:0] MAC_SIG_TEST3 = 16'h8445;

    // Engine states, Gray along idle, run, done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b11
    } engine_state_t;

endpackage

// ---- selftest_lfsr_engine.sv ----
`timescale 1ns/100ps
module selftest_lfsr_engine #(
    parameter int unsigned PATTERNS = 65535
) (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           srst,
    // Control and core response
    input  wire logic                           run,
    input  wire logic [bist_pkg::SIG_WIDTH-1:0] response,
    // Generator, signature and completion
    output logic      [bist_pkg::SIG_WIDTH-1:0] pattern,
    output logic      [bist_pkg::SIG_WIDTH-1:0] signature,
    output logic                                done
);
    import bist_pkg::*;

    localparam logic [SIG_WIDTH-1:0] PATTERN_LOAD = SIG_WIDTH'(PATTERNS);

    engine_state_t        state_reg;
    engine_state_t        state_next;
    logic [SIG_WIDTH-1:0] lfsr_reg;
    logic [SIG_WIDTH-1:0] lfsr_next;
    logic [SIG_WIDTH-1:0] misr_reg;
    logic [SIG_WIDTH-1:0] misr_next;
    logic [SIG_WIDTH-1:0] count_reg;
    logic [SIG_WIDTH-1:0] count_next;

    // One Galois step of the maximal-length register
    function automatic logic [SIG_WIDTH-1:0] lfsr_step(input logic [SIG_WIDTH-1:0] v);
        lfsr_step = {v[SIG_WIDTH-2:0], 1'b0} ^ (v[SIG_WIDTH-1] ? LFSR_POLY : '0);
    endfunction

    // Next state; nothing moves while idle, so the core never sees test data
    always_comb
    begin
        state_next = state_reg;
        lfsr_next  = lfsr_reg;
        misr_next  = misr_reg;
        count_next = count_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (run)
                begin
                    state_next = ST_RUN;
                    lfsr_next  = LFSR_SEED;
                    misr_next  = LFSR_SEED;
                    count_next = PATTERN_LOAD;
                end
            end
            ST_RUN:
            begin
                if (!run)
                    state_next = ST_IDLE;
                else
                begin
                    lfsr_next  = lfsr_step(lfsr_reg);
                    misr_next  = lfsr_step(misr_reg) ^ response;
                    count_next = count_reg - 16'h0001;
                    if (count_reg == 16'h0001)
                        state_next = ST_DONE;
                end
            end
            ST_DONE:
            begin
                // Signature is held; a new test needs the run bit cleared first
                if (!run)
                    state_next = ST_IDLE;
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg <= ST_IDLE;
            lfsr_reg  <= LFSR_SEED;
            misr_reg  <= LFSR_SEED;
            count_reg <= 16'h0000;
        end
        else
        begin
            state_reg <= state_next;
            lfsr_reg  <= lfsr_next;
            misr_reg  <= misr_next;
            count_reg <= count_next;
        end
    end

    assign pattern   = lfsr_reg;
    assign signature = misr_reg;
    assign done      = (state_reg == ST_DONE);

    // Checks on the engine
    chk_seed_on_start: assert property (@(posedge clk) disable iff (srst)
        (state_reg == ST_IDLE && run) |=> (lfsr_reg == LFSR_SEED && misr_reg == LFSR_SEED))
        else $error("engine not seeded on start");
    chk_abort_idle: assert property (@(posedge clk) disable iff (srst)
        (state_reg == ST_RUN && !run) |=> state_reg == ST_IDLE)
        else $error("test not aborted when run cleared");
    chk_count_end: assert property (@(posedge clk) disable iff (srst)
        (state_reg == ST_RUN && run && count_reg == 16'h0001) |=> done)
        else $error("test did not end at last pattern");
    chk_idle_quiet: assert property (@(posedge clk) disable iff (srst)
        (state_reg == ST_IDLE && !run) |=> ($stable(lfsr_reg) && $stable(misr_reg)))
        else $error("engine moved while idle");
    chk_lfsr_nonzero: assert property (@(posedge clk) disable iff (srst)
        state_reg == ST_RUN |-> lfsr_reg != '0)
        else $error("generator reached the locked state");
    chk_freeze_done: assert property (@(posedge clk) disable iff (srst)
        (done && run) |=> (done && $stable(misr_reg)))
        else $error("signature changed after completion");
endmodule

// ---- core_bist_signature_engine.sv ----
`timescale 1ns/100ps
module core_bist_signature_engine #(
    parameter int unsigned LINK_TEST_PATTERNS = bist_pkg::LINK_PATTERNS,
    parameter int unsigned MAC_TEST_PATTERNS  = bist_pkg::MAC_PATTERNS
) (
    // Clock and reset
    input  wire logic                            CLK,
    input  wire logic                            SRST,
    // Register access port
    input  wire logic [bist_pkg::ADDR_WIDTH-1:0] REG_ADDR,
    input  wire logic [bist_pkg::SIG_WIDTH-1:0]  REG_WDATA,
    input  wire logic                            REG_WR,
    input  wire logic                            REG_RD,
    output logic      [bist_pkg::SIG_WIDTH-1:0]  REG_RDATA,
    // Open-drain core access interrupt
    input  wire logic                            CORE_ACCESS_INTERRUPT_I,
    output logic                                 CORE_ACCESS_INTERRUPT_O,
    output logic                                 CORE_ACCESS_INTERRUPT_OE_N,
    // Link core controls
    output logic                                 ELASTIC_BUFFER_LOCAL_LOOPBACK,
    output logic                                 SELFTEST_ACTIVE
);
    import bist_pkg::*;

    // Control and setup registers
    logic [SIG_WIDTH-1:0] link_ctrl_a_reg;
    logic [SIG_WIDTH-1:0] link_ctrl_a_next;
    logic [SIG_WIDTH-1:0] setup_reg [SETUP_REGS];
    logic [SIG_WIDTH-1:0] setup_next [SETUP_REGS];
    logic [SIG_WIDTH-1:0] snap_reg [SETUP_REGS];
    logic [SIG_WIDTH-1:0] snap_next [SETUP_REGS];
    logic                 mac_run_q_reg;
    logic                 mac_run_q_next;

    // Port outputs and the registered interrupt pin level
    logic [SIG_WIDTH-1:0] rdata_reg;
    logic [SIG_WIDTH-1:0] rdata_next;
    logic                 int_oe_n_reg;
    logic                 int_oe_n_next;
    logic                 loopback_reg;
    logic                 loopback_next;
    logic                 active_reg;
    logic                 active_next;
    logic                 pin_level_reg;
    logic                 pin_level_next;

    // Decode and engine connections
    logic                 setup_hit;
    logic [2:0]           setup_idx;
    logic                 link_run;
    logic                 mac_run;
    logic                 mac_start;
    logic [SIG_WIDTH-1:0] link_pattern;
    logic [SIG_WIDTH-1:0] link_sig;
    logic                 link_done;
    logic [SIG_WIDTH-1:0] mac_pattern;
    logic [SIG_WIDTH-1:0] mac_sig;
    logic                 mac_done;
    logic [SIG_WIDTH-1:0] link_response;
    logic [SIG_WIDTH-1:0] mac_response;

    // Map the media-access setup offsets onto the storage index
    always_comb
    begin
        setup_hit = 1'b1;
        setup_idx = 3'h0;
        case (REG_ADDR)
            MAC_CTRL_A_OFFSET:  setup_idx = 3'h0;
            MAC_CTRL_B_OFFSET:  setup_idx = 3'h1;
            SHORT_ADDR_OFFSET:  setup_idx = 3'h2;
            LONG_ADDR_A_OFFSET: setup_idx = 3'h3;
            LONG_ADDR_B_OFFSET: setup_idx = 3'h4;
            LONG_ADDR_C_OFFSET: setup_idx = 3'h5;
            ROTATION_OFFSET:    setup_idx = 3'h6;
            TIMERS_OFFSET:      setup_idx = 3'h7;
            default:            setup_hit = 1'b0;
        endcase
    end

    assign link_run  = link_ctrl_a_reg[RUN_BIT];
    assign mac_run   = setup_reg[0][RUN_BIT];
    assign mac_start = mac_run && !mac_run_q_reg;

    // Link core response: pattern shaped by the low byte of link control A, loopback bit included
    assign link_response = link_pattern ^ {link_ctrl_a_reg[7:0], link_pattern[15:8]};

    // Media-access response uses only the pattern and the start-time setup
    // snapshot; no pin path exists, so outside activity cannot skew the sum
    assign mac_response = mac_pattern ^ snap_reg[mac_pattern[2:0]];

    // Register writes; the control A write carrying the run bit starts the test
    always_comb
    begin
        link_ctrl_a_next = link_ctrl_a_reg;
        for (int i = 0; i < SETUP_REGS; i++)
            setup_next[i] = setup_reg[i];
        if (REG_WR && REG_ADDR == LINK_CTRL_A_OFFSET)
            link_ctrl_a_next = REG_WDATA;
        if (REG_WR && setup_hit)
            setup_next[setup_idx] = REG_WDATA;
        mac_run_q_next = mac_run;
    end

    // Capture every setup value as the media-access test begins
    always_comb
    begin
        for (int i = 0; i < SETUP_REGS; i++)
            snap_next[i] = mac_start ? setup_reg[i] : snap_reg[i];
    end

    // Read data, interrupt and pin outputs
    always_comb
    begin
        rdata_next = rdata_reg;
        if (REG_RD)
        begin
            if (setup_hit)
                rdata_next = setup_reg[setup_idx];
            else
            begin
                case (REG_ADDR)
                    LINK_CTRL_A_OFFSET: rdata_next = link_ctrl_a_reg;
                    LINK_STATUS_OFFSET:
                    begin
                        rdata_next                 = 16'h0000;
                        rdata_next[STAT_LINK_DONE] = link_done;
                        rdata_next[STAT_MAC_DONE]  = mac_done;
                        rdata_next[STAT_INT_PIN]   = pin_level_reg;
                    end
                    LINK_SIG_OFFSET:    rdata_next = link_sig;
                    MAC_SIG_OFFSET:     rdata_next = mac_sig;
                    default:            rdata_next = 16'h0000;
                endcase
            end
        end
        // Held only while the run bit stays set, so reads never clear it
        int_oe_n_next  = !((link_done && link_run) || (mac_done && mac_run));
        loopback_next  = link_ctrl_a_reg[LOOPBACK_BIT];
        active_next    = link_run || mac_run;
        pin_level_next = CORE_ACCESS_INTERRUPT_I;
    end

    // Register stage
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            link_ctrl_a_reg <= CTRL_RESET;
            for (int i = 0; i < SETUP_REGS; i++)
            begin
                setup_reg[i] <= SETUP_RESET;
                snap_reg[i]  <= SETUP_RESET;
            end
            mac_run_q_reg <= 1'b0;
            rdata_reg     <= 16'h0000;
            int_oe_n_reg  <= 1'b1;
            loopback_reg  <= 1'b0;
            active_reg    <= 1'b0;
            pin_level_reg <= 1'b1;
        end
        else
        begin
            link_ctrl_a_reg <= link_ctrl_a_next;
            for (int i = 0; i < SETUP_REGS; i++)
            begin
                setup_reg[i] <= setup_next[i];
                snap_reg[i]  <= snap_next[i];
            end
            mac_run_q_reg <= mac_run_q_next;
            rdata_reg     <= rdata_next;
            int_oe_n_reg  <= int_oe_n_next;
            loopback_reg  <= loopback_next;
            active_reg    <= active_next;
            pin_level_reg <= pin_level_next;
        end
    end

    // Link core engine
    selftest_lfsr_engine #(
        .PATTERNS  (LINK_TEST_PATTERNS)
    ) link_engine (
        .clk       (CLK),
        .srst      (SRST),
        .run       (link_run),
        .response  (link_response),
        .pattern   (link_pattern),
        .signature (link_sig),
        .done      (link_done)
    );

    // Media-access core engine
    selftest_lfsr_engine #(
        .PATTERNS  (MAC_TEST_PATTERNS)
    ) mac_engine (
        .clk       (CLK),
        .srst      (SRST),
        .run       (mac_run),
        .response  (mac_response),
        .pattern   (mac_pattern),
        .signature (mac_sig),
        .done      (mac_done)
    );

    // Open drain: only ever pulls low
    assign CORE_ACCESS_INTERRUPT_O       = 1'b0;
    assign CORE_ACCESS_INTERRUPT_OE_N    = int_oe_n_reg;
    assign REG_RDATA                     = rdata_reg;
    assign ELASTIC_BUFFER_LOCAL_LOOPBACK = loopback_reg;
    assign SELFTEST_ACTIVE               = active_reg;

    // Checks at the ports
    chk_int_on_done: assert property (@(posedge CLK) disable iff (SRST)
        (link_done && link_run) |=> !CORE_ACCESS_INTERRUPT_OE_N)
        else $error("interrupt missing after link completion");
    chk_int_clear_run: assert property (@(posedge CLK) disable iff (SRST)
        (!link_run && !mac_run) |=> CORE_ACCESS_INTERRUPT_OE_N)
        else $error("interrupt held after run bits cleared");
    chk_int_read_keep: assert property (@(posedge CLK) disable iff (SRST)
        (REG_RD && mac_done && mac_run && !REG_WR) |=> ##1 !CORE_ACCESS_INTERRUPT_OE_N)
        else $error("read cleared the interrupt");
    chk_mac_sig_read: assert property (@(posedge CLK) disable iff (SRST)
        (REG_RD && REG_ADDR == MAC_SIG_OFFSET) |=> REG_RDATA == $past(mac_sig))
        else $error("media-access signature read wrong");
    chk_mac_start: assert property (@(posedge CLK) disable iff (SRST)
        (REG_WR && REG_ADDR == MAC_CTRL_A_OFFSET && REG_WDATA[RUN_BIT] && !mac_run)
        |=> ##1 (mac_engine.state_reg == ST_RUN))
        else $error("control A write did not start the test");
    chk_snap_held: assert property (@(posedge CLK) disable iff (SRST)
        (mac_run && !mac_start) |=> $stable(snap_reg[1]) && $stable(snap_reg[7]))
        else $error("setup snapshot changed during test");
    chk_link_abort: assert property (@(posedge CLK) disable iff (SRST)
        (link_engine.state_reg == ST_RUN && !link_run) |=> ##1 CORE_ACCESS_INTERRUPT_OE_N)
        else $error("abort raised the interrupt");

    cov_link_done: cover property (@(posedge CLK) disable iff (SRST)
        link_done && link_run);
    cov_mac_done: cover property (@(posedge CLK) disable iff (SRST)
        mac_done && mac_run);
    cov_abort: cover property (@(posedge CLK) disable iff (SRST)
        link_engine.state_reg == ST_RUN && !link_run);
    cov_sig_read: cover property (@(posedge CLK) disable iff (SRST)
        REG_RD && REG_ADDR == MAC_SIG_OFFSET && mac_done);
endmodule

// ---- node_host_model.sv ----
`timescale 1ns/100ps
module node_host_model (
    // Clock
    input  wire logic                             clk,
    // Register access port, host side
    output logic      [bist_pkg::ADDR_WIDTH-1:0]  reg_addr,
    output logic      [bist_pkg::SIG_WIDTH-1:0]   reg_wdata,
    output logic                                  reg_wr,
    output logic                                  reg_rd,
    input  wire logic [bist_pkg::SIG_WIDTH-1:0]   reg_rdata,
    // Open-drain interrupt wire
    input  wire logic                             irq_oe_n,
    output logic                                  irq_level
);
    import bist_pkg::*;

    // Pull-up on the shared wire: a released pin reads high, never a stale value
    assign irq_level = irq_oe_n ? 1'b1 : 1'b0;

    // Idle bus values at time zero
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // Setup register order of the media-access sequence, control A last
    function automatic logic [7:0] off_of(input int i);
        case (i)
            0:       return MAC_CTRL_B_OFFSET;
            1:       return SHORT_ADDR_OFFSET;
            2:       return LONG_ADDR_A_OFFSET;
            3:       return LONG_ADDR_B_OFFSET;
            4:       return LONG_ADDR_C_OFFSET;
            5:       return ROTATION_OFFSET;
            6:       return TIMERS_OFFSET;
            default: return MAC_CTRL_A_OFFSET;
        endcase
    endfunction

    // One-cycle write strobe; address and data inverted afterwards so nothing leans on them
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
        @(posedge clk);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~addr;
        reg_wdata <= ~data;
    endtask

    // Read data lands at the edge that takes the strobe; the task samples it one edge later
    task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
        @(posedge clk);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~addr;
        @(posedge clk);
        #1;
        data = reg_rdata;
    endtask

    // Setup writes first, control A last, which starts the test
    task automatic run_vector(input logic [15:0] v [8]);
        for (int i = 0; i < 8; i++)
        begin
            write_reg(off_of(i), v[i]);
        end
    endtask
endmodule

// ---- core_bist_signature_engine_tb_top.sv ----
`timescale 1ns/100ps
module core_bist_signature_engine_tb_top;
    import bist_pkg::*;

    // Short test lengths keep the run brief
    localparam int unsigned LINK_N = 20;
    localparam int unsigned MAC_N  = 24;

    logic        clk;
    logic        srst;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd_stb;
    logic [15:0] rdata;
    logic        irq_pin;
    logic        irq_drv;
    logic        oe_n;
    logic        loopback;
    logic        active;
    int          err_count;
    int          checks_done;
    int          seed;
    logic [15:0] rd;
    logic [15:0] sig_a;
    logic [15:0] shadow [8];
    int          sig_q [$];
    logic [15:0] vec [3][8] = '{
        '{16'h0200, 16'h7777, 16'haaaa, 16'hbbbb, 16'hcccc, 16'hff00, 16'haacc, 16'h88c4},
        '{16'h82ff, 16'h8888, 16'h5555, 16'h4444, 16'h3333, 16'h00ff, 16'h5533, 16'hf127},
        '{16'h13ff, 16'h137f, 16'h37f1, 16'h7f13, 16'hf137, 16'hfec8, 16'hf0fc, 16'ha414}};

    core_bist_signature_engine #(
        .LINK_TEST_PATTERNS (LINK_N),
        .MAC_TEST_PATTERNS  (MAC_N)
    ) dut (
        .CLK                           (clk),
        .SRST                          (srst),
        .REG_ADDR                      (addr),
        .REG_WDATA                     (wdata),
        .REG_WR                        (wr),
        .REG_RD                        (rd_stb),
        .REG_RDATA                     (rdata),
        .CORE_ACCESS_INTERRUPT_I       (irq_pin),
        .CORE_ACCESS_INTERRUPT_O       (irq_drv),
        .CORE_ACCESS_INTERRUPT_OE_N    (oe_n),
        .ELASTIC_BUFFER_LOCAL_LOOPBACK (loopback),
        .SELFTEST_ACTIVE               (active)
    );

    node_host_model host (
        .clk       (clk),
        .reg_addr  (addr),
        .reg_wdata (wdata),
        .reg_wr    (wr),
        .reg_rd    (rd_stb),
        .reg_rdata (rdata),
        .irq_oe_n  (oe_n),
        .irq_level (irq_pin)
    );

    // Free-running byte clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic do_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
    endtask

    // Called at the edge that took the run write; interrupt shows just after edge n+2
    task automatic wait_irq(input int n);
        repeat (n + 1) @(posedge clk);
        #1;
        chk("irq early", {15'h0, oe_n}, 16'h0001);
        @(posedge clk);
        #1;
        chk("irq on done", {15'h0, oe_n}, 16'h0000);
        chk("active in run", {15'h0, active}, 16'h0001);
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial
    begin
        #200000;
        err_count++;
        wrap_up();
    end

    initial
    begin
        seed = 32'h0e3e4d72;
        err_count = 0;
        checks_done = 0;
        srst = 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        // Quiet after reset, then random setup values read back
        #1;
        chk("active idle", {15'h0, active}, 16'h0000);
        chk("irq idle", {15'h0, oe_n}, 16'h0001);
        chk("irq drive level", {15'h0, irq_drv}, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            host.read_reg(host.off_of(i), rd);
            chk("reset value", rd, 16'h0000);
            shadow[i] = 16'($random(seed)) & ((i == 7) ? 16'hfffb : 16'hffff);
            host.write_reg(host.off_of(i), shadow[i]);
        end
        for (int i = 0; i < 8; i++)
        begin
            host.read_reg(host.off_of(i), rd);
            chk("setup readback", rd, shadow[i]);
        end
        host.write_reg(MAC_SIG_OFFSET, 16'hffff);
        host.read_reg(MAC_SIG_OFFSET, rd);
        chk("signature read only", rd, LFSR_SEED);
        host.write_reg(8'h33, 16'h1234);
        host.read_reg(8'h33, rd);
        chk("unmapped", rd, 16'h0000);
        $display("test registers done");
        // Link test with loopback, frozen signature, sticky interrupt, rerun
        do_reset();
        host.write_reg(LINK_CTRL_A_OFFSET, 16'h0008);
        @(posedge clk);
        #1;
        chk("loopback", {15'h0, loopback}, 16'h0001);
        host.read_reg(LINK_STATUS_OFFSET, rd);
        chk("status idle", rd, 16'h0004);
        host.write_reg(LINK_CTRL_A_OFFSET, 16'h000c);
        wait_irq(LINK_N);
        host.read_reg(LINK_SIG_OFFSET, sig_a);
        repeat (30) @(posedge clk);
        host.read_reg(LINK_SIG_OFFSET, rd);
        chk("link sig frozen", rd, sig_a);
        host.read_reg(LINK_STATUS_OFFSET, rd);
        chk("status done", rd, 16'h0001);
        chk("irq after reads", {15'h0, oe_n}, 16'h0000);
        host.write_reg(LINK_CTRL_A_OFFSET, 16'h0008);
        repeat (3) @(posedge clk);
        #1;
        chk("irq cleared", {15'h0, oe_n}, 16'h0001);
        chk("active off", {15'h0, active}, 16'h0000);
        host.write_reg(LINK_CTRL_A_OFFSET, 16'h000c);
        wait_irq(LINK_N);
        host.read_reg(LINK_SIG_OFFSET, rd);
        chk("link rerun sig", rd, sig_a);
        $display("test link done");
        // Abort in mid-test: no interrupt ever follows
        host.write_reg(LINK_CTRL_A_OFFSET, 16'h0000);
        host.write_reg(LINK_CTRL_A_OFFSET, 16'h0004);
        repeat (5) @(posedge clk);
        host.write_reg(LINK_CTRL_A_OFFSET, 16'h0000);
        repeat (LINK_N + 10) @(posedge clk);
        #1;
        chk("abort no irq", {15'h0, oe_n}, 16'h0001);
        chk("abort idle", {15'h0, active}, 16'h0000);
        $display("test abort done");
        // Media-access vectors, then vector one again
        for (int v = 0; v < 4; v++)
        begin
            do_reset();
            host.run_vector(vec[v % 3]);
            wait_irq(MAC_N);
            host.read_reg(MAC_SIG_OFFSET, rd);
            sig_q.push_back(int'(rd));
            host.read_reg(LINK_STATUS_OFFSET, rd);
            chk("mac status done", rd, 16'h0002);
        end
        do_reset();
        @(posedge clk);
        #1;
        chk("irq after reset", {15'h0, oe_n}, 16'h0001);
        chk("sig 1 vs 2", {15'h0, sig_q[0] != sig_q[1]}, 16'h0001);
        chk("sig 2 vs 3", {15'h0, sig_q[1] != sig_q[2]}, 16'h0001);
        chk("sig 1 vs 3", {15'h0, sig_q[0] != sig_q[2]}, 16'h0001);
        chk("sig repeat", 16'(sig_q[3]), 16'(sig_q[0]));
        $display("test media access done");
        wrap_up();
    end
endmodule
